// file: rpd_decoder.v
/*
 * receive process data decoder: turns each received eight-byte object
 * into motion, sequence, current and command requests, with an
 * AXI4-Lite register slave for configuration and status.
 * assumes rxObject/rxValid come from fieldbus logic on the same clock,
 * rxValid high for one cycle per received object.
 */
`timescale 1ns/1ps
`include "rpd_map.vh"

module rpd_decoder #(
	parameter HOME_W = 3
) (
	// clock and reset
	input  wire              clock,
	input  wire              rst_n,
	// received object
	input  wire [63:0]       rxObject,
	input  wire              rxValid,
	// axi4-lite write
	input  wire [7:0]        s_axi_awaddr,
	input  wire              s_axi_awvalid,
	output wire              s_axi_awready,
	input  wire [31:0]       s_axi_wdata,
	input  wire [3:0]        s_axi_wstrb,
	input  wire              s_axi_wvalid,
	output wire              s_axi_wready,
	output wire [1:0]        s_axi_bresp,
	output wire              s_axi_bvalid,
	input  wire              s_axi_bready,
	// axi4-lite read
	input  wire [7:0]        s_axi_araddr,
	input  wire              s_axi_arvalid,
	output wire              s_axi_arready,
	output wire [31:0]       s_axi_rdata,
	output wire [1:0]        s_axi_rresp,
	output wire              s_axi_rvalid,
	input  wire              s_axi_rready,
	// inputs to the controller
	output wire [7:0]        generalIn,
	output wire [7:0]        systemIn,
	// sequence control
	output wire              seqStart,
	output wire [6:0]        seqNumber,
	output wire              seqAbort,
	// motion control
	output wire              motionStop,
	output wire              contMovePositive,
	output wire              contMoveNegative,
	output wire              homeSeekNegative,
	output wire [HOME_W-1:0] homeTypeSetting,
	output wire              motorCurrentEnable,
	output wire              brakeRelease,
	// command handshake
	output wire              commandExecute,
	output wire [13:0]       commandCode,
	output wire [31:0]       commandData
);

	// ==========================================================
	// helpers
	function [31:0] mergeBytes;
		input [31:0] oldVal;
		input [31:0] newVal;
		input [3:0]  strb;
		integer k;
		begin
			for (k = 0; k < 4; k = k + 1) begin
				mergeBytes[k*8 +: 8] = strb[k] ? newVal[k*8 +: 8] : oldVal[k*8 +: 8];
			end
		end
	endfunction

	// ==========================================================
	// state
	reg              awready_r, wready_r, bvalid_r, awHeld_r, wHeld_r, arready_r, rvalid_r;
	reg              rangeErr_r, seqStart_r, seqAbort_r, motionStop_r, contPos_r, contNeg_r;
	reg              homeSeek_r, current_r, brake_r, cmdExec_r;
	reg [1:0]        bresp_r, rresp_r;
	reg [7:0]        awAddr_r, assign_r, generalIn_r, systemIn_r;
	reg [31:0]       wData_r, rdata_r, cmdData_r;
	reg [3:0]        wStrb_r, ctrl_r;
	reg [15:0]       rxCount_r, lastCtl_r;
	reg [6:0]        seqNumber_r;
	reg [HOME_W-1:0] homeType_r;
	reg [13:0]       cmdCode_r;

	wire [7:0]  curIn, generalNxt, systemNxt;
	wire [6:0]  seqNum;
	wire [1:0]  rise;
	wire        seqOk, startBit, abortBit, cposBit, cnegBit, startAct, doWrite, clrErr, setErr;
	// lanes merge at full word width; the registers keep only their low bits
	wire [31:0] ctrlMerged   = mergeBytes({28'h0000000, ctrl_r}, wData_r, wStrb_r);
	wire [31:0] assignMerged = mergeBytes({24'h000000, assign_r}, wData_r, wStrb_r);
	reg  [31:0] rdMux;
	reg         rdHit;

	// ==========================================================
	// decode of the received object
	assign startBit = rxObject[`OBJ_START];
	assign abortBit = rxObject[`OBJ_ABORT];
	assign cposBit  = rxObject[`OBJ_CPOS];
	assign cnegBit  = rxObject[`OBJ_CNEG];
	assign startAct = ctrl_r[`CTRL_STARTACT];

	// between receptions the held inputs are re-split, so a new mask acts at once
	assign curIn = rxValid ? rxObject[`OBJ_INPUTS] : lastCtl_r[`STAT_BYTE0];

	seq_select u_seq (
		.remoteIn   (curIn),
		.assignMask (assign_r),
		.generalIn  (generalNxt),
		.systemIn   (systemNxt),
		.seqNumber  (seqNum),
		.seqInRange (seqOk)
	);

	rx_edge_capture #(
		.W (2)
	) u_edge (
		.clock  (clock),
		.rst_n  (rst_n),
		.sample (rxValid),
		.bits   ({rxObject[`OBJ_COMMAND_TRIGGER], startBit}),
		.rise   (rise)
	);

	// out-of-range numbers are dropped and flagged instead of started
	assign setErr = rise[0] & ~abortBit & ~seqOk;

	// ==========================================================
	// request generation
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			generalIn_r  <= 8'h00;
			systemIn_r   <= 8'h00;
			seqStart_r   <= 1'b0;
			seqNumber_r  <= 7'h00;
			seqAbort_r   <= 1'b0;
			motionStop_r <= 1'b0;
			contPos_r    <= 1'b0;
			contNeg_r    <= 1'b0;
			homeSeek_r   <= 1'b0;
			homeType_r   <= {HOME_W{1'b0}};
			current_r    <= 1'b0;
			brake_r      <= 1'b0;
			cmdExec_r    <= 1'b0;
			cmdCode_r    <= 14'h0000;
			cmdData_r    <= 32'h00000000;
			lastCtl_r    <= 16'h0000;
			rxCount_r    <= 16'h0000;
		end else begin
			generalIn_r <= generalNxt;
			systemIn_r  <= systemNxt;
			homeType_r  <= ctrl_r[`CTRL_HOMETYPE];
			// abort outranks any start carried in the same object
			seqStart_r   <= rise[0] & ~abortBit & seqOk;
			seqAbort_r   <= rxValid & (abortBit | (startAct & ~startBit));
			motionStop_r <= rxValid & abortBit;
			// opposite directions in one object cancel each other
			contPos_r    <= rxValid & cposBit & ~cnegBit & ~abortBit;
			contNeg_r    <= rxValid & cnegBit & ~cposBit & ~abortBit;
			homeSeek_r   <= rxValid & rxObject[`OBJ_HOME] & ~abortBit;
			cmdExec_r    <= rise[1];
			if (rise[0]) begin
				seqNumber_r <= seqNum;
			end
			if (rise[1]) begin
				cmdCode_r <= rxObject[`OBJ_CMD];
				cmdData_r <= rxObject[`OBJ_DATA];
			end
			if (rxValid) begin
				current_r <= rxObject[`OBJ_CURR] & ~rxObject[`OBJ_FREE];
				brake_r   <= rxObject[`OBJ_FREE];
				lastCtl_r <= rxObject[15:0];
				rxCount_r <= rxCount_r + 16'h0001;
			end
		end
	end

	// ==========================================================
	// axi4-lite write channel
	assign doWrite = awHeld_r & wHeld_r & ~bvalid_r;
	assign clrErr  = doWrite & (awAddr_r == `ADDR_STATUS) & wStrb_r[2] & wData_r[`STAT_RANGEERR];

	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			awready_r <= 1'b1;
			wready_r  <= 1'b1;
			awHeld_r  <= 1'b0;
			wHeld_r   <= 1'b0;
			awAddr_r  <= 8'h00;
			wData_r   <= 32'h00000000;
			wStrb_r   <= 4'h0;
			bvalid_r  <= 1'b0;
			bresp_r   <= `RESP_OKAY;
			ctrl_r    <= `CTRL_RESET;
			assign_r  <= `ASSIGN_RESET;
		end else begin
			if (s_axi_awvalid && awready_r) begin
				awready_r <= 1'b0;
				awHeld_r  <= 1'b1;
				awAddr_r  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && wready_r) begin
				wready_r <= 1'b0;
				wHeld_r  <= 1'b1;
				wData_r  <= s_axi_wdata;
				wStrb_r  <= s_axi_wstrb;
			end
			if (doWrite) begin
				awHeld_r <= 1'b0;
				wHeld_r  <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r  <= `RESP_OKAY;
				case (awAddr_r)
					`ADDR_CTRL:   ctrl_r   <= ctrlMerged[3:0];
					`ADDR_ASSIGN: assign_r <= assignMerged[7:0];
					`ADDR_STATUS, `ADDR_CMDCODE, `ADDR_CMDDATA, `ADDR_RXCOUNT: bresp_r <= `RESP_OKAY;
					default:      bresp_r  <= `RESP_SLVERR;
				endcase
			end
			if (bvalid_r && s_axi_bready) begin
				bvalid_r  <= 1'b0;
				awready_r <= 1'b1;
				wready_r  <= 1'b1;
			end
		end
	end

	// sticky flag: a new error in the clearing cycle survives
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rangeErr_r <= 1'b0;
		end else begin
			rangeErr_r <= setErr | (rangeErr_r & ~clrErr);
		end
	end

	// ==========================================================
	// axi4-lite read channel
	always @* begin
		rdMux = 32'h00000000;
		rdHit = 1'b1;
		case (s_axi_araddr)
			`ADDR_CTRL:    rdMux[3:0]  = ctrl_r;
			`ADDR_ASSIGN:  rdMux[7:0]  = assign_r;
			`ADDR_STATUS: begin
				rdMux[15:0]           = lastCtl_r;
				rdMux[`STAT_RANGEERR] = rangeErr_r;
				rdMux[`STAT_CURRENT]  = current_r;
				rdMux[`STAT_BRAKE]    = brake_r;
			end
			`ADDR_CMDCODE: rdMux[13:0] = cmdCode_r;
			`ADDR_CMDDATA: rdMux       = cmdData_r;
			`ADDR_RXCOUNT: rdMux[15:0] = rxCount_r;
			default:       rdHit       = 1'b0;
		endcase
	end

	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			arready_r <= 1'b1;
			rvalid_r  <= 1'b0;
			rresp_r   <= `RESP_OKAY;
			rdata_r   <= 32'h00000000;
		end else begin
			if (s_axi_arvalid && arready_r) begin
				arready_r <= 1'b0;
				rvalid_r  <= 1'b1;
				rdata_r   <= rdMux;
				rresp_r   <= rdHit ? `RESP_OKAY : `RESP_SLVERR;
			end else if (rvalid_r && s_axi_rready) begin
				rvalid_r  <= 1'b0;
				arready_r <= 1'b1;
			end
		end
	end

	// ==========================================================
	// outputs
	assign s_axi_awready      = awready_r;
	assign s_axi_wready       = wready_r;
	assign s_axi_bresp        = bresp_r;
	assign s_axi_bvalid       = bvalid_r;
	assign s_axi_arready      = arready_r;
	assign s_axi_rdata        = rdata_r;
	assign s_axi_rresp        = rresp_r;
	assign s_axi_rvalid       = rvalid_r;
	assign generalIn          = generalIn_r;
	assign systemIn           = systemIn_r;
	assign seqStart           = seqStart_r;
	assign seqNumber          = seqNumber_r;
	assign seqAbort           = seqAbort_r;
	assign motionStop         = motionStop_r;
	assign contMovePositive   = contPos_r;
	assign contMoveNegative   = contNeg_r;
	assign homeSeekNegative   = homeSeek_r;
	assign homeTypeSetting    = homeType_r;
	assign motorCurrentEnable = current_r;
	assign brakeRelease       = brake_r;
	assign commandExecute     = cmdExec_r;
	assign commandCode        = cmdCode_r;
	assign commandData        = cmdData_r;

endmodule // rpd_decoder

// file: rpd_map.vh
/*
 * field layout of the eight-byte receive object, register offsets and
 * reset values for the receive process data decoder.
 * assumes it is included by bare name from the design files.
 */
`ifndef RPD_MAP_VH
`define RPD_MAP_VH

// ==========================================================
// receive object fields
`define OBJ_INPUTS      7:0
`define OBJ_START       8
`define OBJ_CPOS        9
`define OBJ_CNEG        10
`define OBJ_HOME        11
`define OBJ_ABORT       12
`define OBJ_CURR        13
`define OBJ_FREE        14
`define OBJ_CMD         29:16
`define OBJ_COMMAND_TRIGGER        30
`define OBJ_DATA        63:32
`define SEQ_NUM         6:0
`define SEQ_MAX         7'h63

// ==========================================================
// register offsets
`define ADDR_CTRL       8'h00
`define ADDR_ASSIGN     8'h04
`define ADDR_STATUS     8'h08
`define ADDR_CMDCODE    8'h0c
`define ADDR_CMDDATA    8'h10
`define ADDR_RXCOUNT    8'h14

// ==========================================================
// register fields and reset values
`define CTRL_STARTACT   0
`define CTRL_HOMETYPE   3:1
`define CTRL_RESET      4'h0
`define ASSIGN_RESET    8'h00
`define STAT_BYTE0      7:0
`define STAT_BYTE1      15:8
`define STAT_RANGEERR   16
`define STAT_CURRENT    17
`define STAT_BRAKE      18

// ==========================================================
// bus responses
`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10

`endif

// file: rx_edge_capture.v
/*
 * remembers selected bits of the last received object and flags
 * 0-to-1 changes against the new one.
 * assumes sample is a one-cycle strobe on the same clock.
 */
`timescale 1ns/1ps

module rx_edge_capture #(
	parameter W = 2
) (
	// clock and reset
	input  wire         clock,
	input  wire         rst_n,
	// reception
	input  wire         sample,
	input  wire [W-1:0] bits,
	// result, valid while sample is high
	output wire [W-1:0] rise
);

	reg [W-1:0] prev_r;

	// ==========================================================
	// previous object, updated only on a reception
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			prev_r <= {W{1'b0}};
		end else if (sample) begin
			prev_r <= bits;
		end
	end

	genvar i;
	generate
		for (i = 0; i < W; i = i + 1) begin : g_rise
			assign rise[i] = sample & bits[i] & ~prev_r[i];
		end
	endgenerate

endmodule // rx_edge_capture

// file: seq_select.v
/*
 * splits the remote inputs into general and system inputs and forms
 * the sequence number from the first seven general inputs.
 * assumes a purely combinational use by the decoder.
 */
`timescale 1ns/1ps
`include "rpd_map.vh"

module seq_select (
	// remote inputs and assignment
	input  wire [7:0] remoteIn,
	input  wire [7:0] assignMask,
	// results
	output wire [7:0] generalIn,
	output wire [7:0] systemIn,
	output wire [6:0] seqNumber,
	output wire       seqInRange
);

	// ==========================================================
	// assigned inputs feed their system function only
	assign systemIn   = remoteIn & assignMask;
	assign generalIn  = remoteIn & ~assignMask;

	// number comes from general inputs one to seven
	assign seqNumber  = generalIn[`SEQ_NUM];
	assign seqInRange = (seqNumber <= `SEQ_MAX);

endmodule // seq_select

// file: rpd_decoder_assertions.sv
/*
 * port checker for the receive object decoder.
 * assumes a bind onto rpd_decoder, one clock and an active-low reset.
 */
`timescale 1ns/1ps

module rpd_decoder_assertions (
	// clock and reset
	input wire        clock,
	input wire        rst_n,
	// received object
	input wire [63:0] rxObject,
	input wire        rxValid,
	// decoded outputs
	input wire [7:0]  generalIn,
	input wire [7:0]  systemIn,
	input wire        seqStart,
	input wire [6:0]  seqNumber,
	input wire        seqAbort,
	input wire        motionStop,
	input wire        contMovePositive,
	input wire        contMoveNegative,
	input wire        homeSeekNegative,
	input wire        motorCurrentEnable,
	input wire        brakeRelease,
	input wire        commandExecute,
	input wire [13:0] commandCode,
	input wire [31:0] commandData
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);

	// ==========================================================
	// object steps
	sequence abortObj;
		rxValid && rxObject[12];
	endsequence
	sequence trigObj;
		rxValid && rxObject[30];
	endsequence

	// ==========================================================
	// checks
	seq_pulse_a: assert property (seqStart |=> !seqStart)
		else $error("sequence start longer than one cycle");
	seq_range_a: assert property (seqStart |-> seqNumber <= 7'h63 && $past(rxValid && rxObject[8]))
		else $error("sequence start without start bit or with out of range number");
	input_split_a: assert property ((generalIn & systemIn) == 8'h00)
		else $error("assigned input still seen as general");
	cmd_cause_a: assert property (commandExecute |-> $past(rxValid && rxObject[30]))
		else $error("command executed without a trigger object");
	cmd_fields_a: assert property (trigObj ##1 commandExecute |-> commandCode == $past(rxObject[29:16])
		&& commandData == $past(rxObject[63:32]))
		else $error("command executed with wrong code or data");
	cmd_pulse_a: assert property (commandExecute |=> !commandExecute)
		else $error("command execute longer than one cycle");
	cont_pos_a: assert property (contMovePositive |-> $past(rxValid && rxObject[9] && !rxObject[12]))
		else $error("positive move without its bit");
	cont_neg_a: assert property (contMoveNegative |-> $past(rxValid && rxObject[10] && !rxObject[12]))
		else $error("negative move without its bit");
	home_seek_a: assert property (homeSeekNegative |-> $past(rxValid && rxObject[11] && !rxObject[12]))
		else $error("home seek without its bit");
	abort_stop_a: assert property (abortObj |=> motionStop && seqAbort)
		else $error("abort bit did not stop motion and sequence");
	motor_current_a: assert property (rxValid |=> motorCurrentEnable == $past(rxObject[13] && !rxObject[14])
		&& brakeRelease == $past(rxObject[14]))
		else $error("current or brake does not follow object");
endmodule // rpd_decoder_assertions

bind rpd_decoder rpd_decoder_assertions checker0 (
	.clock(clock), .rst_n(rst_n), .rxObject(rxObject), .rxValid(rxValid),
	.generalIn(generalIn), .systemIn(systemIn), .seqStart(seqStart), .seqNumber(seqNumber),
	.seqAbort(seqAbort), .motionStop(motionStop), .contMovePositive(contMovePositive),
	.contMoveNegative(contMoveNegative), .homeSeekNegative(homeSeekNegative),
	.motorCurrentEnable(motorCurrentEnable), .brakeRelease(brakeRelease),
	.commandExecute(commandExecute), .commandCode(commandCode), .commandData(commandData)
);

// file: fieldbus_master.sv
/*
 * fieldbus master model: presents one receive object per call.
 * assumes the decoder samples rxValid on the rising clock edge.
 */
`timescale 1ns/1ps

module fieldbus_master (
	// clock
	input  wire        clock,
	// receive object
	output reg  [63:0] rxObject,
	output reg         rxValid
);
	initial begin
		rxObject = 64'h0;
		rxValid  = 1'b0;
	end

	// ==========================================================
	// send, command and trigger travel in one object
	task send(input [63:0] obj);
		begin
			@(posedge clock);
			rxObject <= obj;
			rxValid  <= 1'b1;
			@(posedge clock);
			rxValid  <= 1'b0;
			// stale data is not held, so nothing may read it
			rxObject <= ~obj;
		end
	endtask
endmodule // fieldbus_master

// file: rpd_decoder_tb.sv
/*
 * testbench for the receive object decoder: bus and object tasks.
 * assumes the fieldbus master model and the port checker are compiled.
 */
`timescale 1ns/1ps
`include "rpd_map.vh"

module rpd_decoder_tb;
	// ==========================================================
	// signals
	reg         clock, rst_n, awvalid, wvalid, bready, arvalid, rready;
	reg  [7:0]  awaddr, araddr;
	reg  [31:0] wdata;
	wire        awready, wready, bvalid, arready, rvalid, rxValid;
	wire [1:0]  bresp, rresp;
	wire [31:0] rdata, commandData;
	wire [63:0] rxObject;
	wire [7:0]  generalIn, systemIn;
	wire [6:0]  seqNumber;
	wire [2:0]  homeTypeSetting;
	wire [13:0] commandCode;
	wire        seqStart, seqAbort, motionStop, contMovePositive, contMoveNegative;
	wire        homeSeekNegative, motorCurrentEnable, brakeRelease, commandExecute;
	wire [6:0]  pulses = {seqStart, seqAbort, motionStop, contMovePositive, contMoveNegative,
		homeSeekNegative, commandExecute};
	integer     errors, cmp_count, cycles, i;
	reg  [63:0] cmd;

	fieldbus_master master (.clock(clock), .rxObject(rxObject), .rxValid(rxValid));

	rpd_decoder DUT (
		.clock(clock), .rst_n(rst_n), .rxObject(rxObject), .rxValid(rxValid),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .generalIn(generalIn), .systemIn(systemIn), .seqStart(seqStart),
		.seqNumber(seqNumber), .seqAbort(seqAbort), .motionStop(motionStop),
		.contMovePositive(contMovePositive), .contMoveNegative(contMoveNegative),
		.homeSeekNegative(homeSeekNegative), .homeTypeSetting(homeTypeSetting),
		.motorCurrentEnable(motorCurrentEnable), .brakeRelease(brakeRelease),
		.commandExecute(commandExecute), .commandCode(commandCode), .commandData(commandData)
	);

	// ==========================================================
	// tasks
	task tally_and_finish;
		begin
			$display("comparisons %0d mismatches %0d", cmp_count, errors);
			if (errors == 0 && cmp_count > 0) begin
				$display("SIMULATION PASSED");
			end else begin
				$display("SIMULATION FAILED");
			end
			$finish;
		end
	endtask

	task chk(input string what, input [63:0] e, input [63:0] g);
		begin
			cmp_count = cmp_count + 1;
			if (g !== e) begin
				errors = errors + 1;
				$display("ERROR %s expected %h seen %h", what, e, g);
			end
		end
	endtask

	task axw(input [7:0] a, input [31:0] d, input [1:0] r);
		reg pa, pw;
		begin
			@(posedge clock);
			awaddr  <= a;
			wdata   <= d;
			awvalid <= 1'b1;
			wvalid  <= 1'b1;
			bready  <= 1'b1;
			pa = 1'b1;
			pw = 1'b1;
			while (pa || pw) begin
				@(posedge clock);
				if (pa && awready) begin
					pa = 1'b0;
					awvalid <= 1'b0;
				end
				if (pw && wready) begin
					pw = 1'b0;
					wvalid <= 1'b0;
				end
			end
			do @(posedge clock); while (!bvalid);
			bready <= 1'b0;
			chk("bresp", r, bresp);
		end
	endtask

	task axr(input [7:0] a, input [31:0] e, input [1:0] r);
		begin
			@(posedge clock);
			araddr  <= a;
			arvalid <= 1'b1;
			rready  <= 1'b1;
			do @(posedge clock); while (!arready);
			arvalid <= 1'b0;
			do @(posedge clock); while (!rvalid);
			rready <= 1'b0;
			chk("rdata", e, rdata);
			chk("rresp", r, rresp);
		end
	endtask

	// pulses are settled just after the edge that takes the object
	task obj(input [63:0] o, input [6:0] e);
		begin
			master.send(o);
			#1;
			chk("pulses", e, pulses);
		end
	endtask

	function [63:0] mk(input [7:0] rin, input [7:0] ctl);
		mk = {48'h0, ctl, rin};
	endfunction

	// ==========================================================
	// clock and hang guard
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	always @(posedge clock) begin
		cycles = cycles + 1;
		if (cycles == 3000) begin
			errors = errors + 1;
			tally_and_finish;
		end
	end

	// ==========================================================
	// tests
	initial begin
		errors = 0;
		cmp_count = 0;
		cycles = 0;
		{rst_n, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = 0;
		cmd = {32'h0000_0003, 2'b01, 14'h1c05, 16'h0000};
		repeat (16) @(posedge clock);
		rst_n <= 1'b1;
		axr(`ADDR_CTRL, 32'h0, `RESP_OKAY);
		axr(`ADDR_ASSIGN, 32'h0, `RESP_OKAY);
		axr(8'h18, 32'h0, `RESP_SLVERR);
		axw(8'h18, 32'h1, `RESP_SLVERR);
		axw(`ADDR_CTRL, 32'ha, `RESP_OKAY);
		@(posedge clock);
		#1;
		chk("homeType", 3'h5, homeTypeSetting);
		obj(mk(8'h03, 8'h01), 7'h40);
		chk("seqNumber", 7'h03, seqNumber);
		chk("generalIn", 8'h03, generalIn);
		obj(mk(8'h03, 8'h00), 7'h00);
		axw(`ADDR_ASSIGN, 32'h1, `RESP_OKAY);
		obj(mk(8'h03, 8'h01), 7'h40);
		chk("seqNumber", 7'h02, seqNumber);
		chk("systemIn", 8'h01, systemIn);
		obj(mk(8'h64, 8'h00), 7'h00);
		obj(mk(8'h64, 8'h01), 7'h00);
		axr(`ADDR_STATUS, 32'h0001_0164, `RESP_OKAY);
		axw(`ADDR_STATUS, 32'h0001_0000, `RESP_OKAY);
		axr(`ADDR_STATUS, 32'h0000_0164, `RESP_OKAY);
		axw(`ADDR_CTRL, 32'h1, `RESP_OKAY);
		obj(mk(8'h00, 8'h00), 7'h20);
		axw(`ADDR_CTRL, 32'h0, `RESP_OKAY);
		for (i = 1; i < 5; i = i + 1) begin
			obj(mk(8'h00, 8'h01 << i), (i == 4) ? 7'h30 : 7'h10 >> i);
		end
		obj(mk(8'h00, 8'h13), 7'h30);
		obj(mk(8'h00, 8'h20), 7'h00);
		chk("current", 1'b1, motorCurrentEnable);
		chk("brake", 1'b0, brakeRelease);
		obj(mk(8'h00, 8'h60), 7'h00);
		chk("current", 1'b0, motorCurrentEnable);
		chk("brake", 1'b1, brakeRelease);
		obj(cmd, 7'h01);
		chk("code", 14'h1c05, commandCode);
		chk("data", 32'h3, commandData);
		obj(cmd, 7'h00);
		obj(cmd & ~(64'h1 << 30), 7'h00);
		obj(cmd, 7'h01);
		axr(`ADDR_CMDCODE, 32'h1c05, `RESP_OKAY);
		axr(`ADDR_CMDDATA, 32'h3, `RESP_OKAY);
		axr(`ADDR_RXCOUNT, 32'h11, `RESP_OKAY);
		tally_and_finish;
	end
endmodule // rpd_decoder_tb
